// file: src/jfp_regs.vh
// constants for the jtag flash programming data registers
`ifndef JFP_REGS_VH
`define JFP_REGS_VH
`define JFP_IR_WIDTH 4
`define JFP_IR_CORE_HOLD 4'hc
`define JFP_IR_KEY_UNLOCK 4'h4
`define JFP_IR_CMD_ENTRY 4'h5
`define JFP_IR_PAGE_FILL 4'h6
`define JFP_IR_PAGE_DUMP 4'h7
`define JFP_IR_BYPASS 4'hf
`define JFP_KEY_WIDTH 16
`define JFP_KEY_VALUE 16'ha370
`define JFP_KEY_RESET 16'h0000
`define JFP_CMD_WIDTH 15
`define JFP_CMD_RESET 15'h0000
`define JFP_DONE_BIT 9
`define JFP_PAGE_BYTES 128
`define JFP_BYTE_WIDTH 8
`define JFP_HOLD_TIMEOUT_US 64
`define JFP_CLK_MHZ 40
`define JFP_HOLD_CYCLES (`JFP_HOLD_TIMEOUT_US * `JFP_CLK_MHZ)
`endif

// file: src/jfp_fifo.v
// small valid/ready fifo for page bytes
`timescale 1ns/100ps
module jfp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rstB,
	input wire [WIDTH-1:0] inData,
	input wire inValid,
	output wire inReady,
	output wire [WIDTH-1:0] outData,
	output wire outValid,
	input wire outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_reg;
	reg [AW-1:0] rdPtr_reg;
	reg [AW:0] count_reg;
	wire doWr;
	wire doRd;
	assign inReady = (count_reg != DEPTH[AW:0]);
	assign outValid = (count_reg != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_reg];
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;
	always @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr_reg] <= inData;
		end
	end
	always @(posedge clk or negedge rstB) begin
		if (!rstB) begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (doWr) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (doRd) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
			if (doWr && !doRd) begin
				count_reg <= count_reg + 1'b1;
			end else if (doRd && !doWr) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// file: src/jfp_tap_prog.v
// tap controller and programming data registers, sampled on ref_clk
`timescale 1ns/100ps
`include "jfp_regs.vh"
// Contract
// - key unlock selects 16-bit key register
// - update compares key, enters programming mode
// - enable only for key 1010_0011_0111_0000
// - key register cleared at power-on
// - command entry selects 15-bit command register
// - capture loads previous command result
// - shift emits result, takes new command
// - update presents command to flash inputs
// - idle gives one execute clock
// - page fill: 1024-bit virtual chain, 8-bit
// - page fill bytes stream during shift
// - page dump: 1032-bit virtual chain, 8-bit
// - page dump fetches bytes, ignores input
// - reset register one holds core reset
// - reset lasts timeout after release
// - all shifts least significant bit first
module jfp_tap_prog #(
	parameter HOLD_CYCLES = `JFP_HOLD_CYCLES,
	parameter PAGE_BYTES = `JFP_PAGE_BYTES
) (
	input wire ref_clk,
	input wire rst_b,
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo,
	output reg tdoEn,
	output reg progMode,
	output reg coreReset,
	output reg [14:0] flashCmd,
	output reg flashCmdValid,
	output reg flashExec,
	input wire [14:0] flashResult,
	input wire flashDone,
	output reg [7:0] pageWrData,
	output reg pageWrValid,
	input wire pageWrReady,
	output reg pageRdReq,
	input wire [7:0] pageRdData
);
	localparam TLR = 4'h0, RTI = 4'h1, SDS = 4'h2, CDR = 4'h3, SHDR = 4'h4, E1D = 4'h5;
	localparam PDR = 4'h6, E2D = 4'h7, UDR = 4'h8, SIS = 4'h9, CIR = 4'ha, SHIR = 4'hb;
	localparam E1I = 4'hc, PIR = 4'hd, E2I = 4'he, UIR = 4'hf;
	reg [1:0] rstSync_reg;
	wire rstB;
	reg [2:0] tckSync_reg;
	reg [1:0] tmsSync_reg;
	reg [1:0] tdiSync_reg;
	wire tckRise;
	wire tckFall;
	wire tmsS;
	wire tdiS;
	reg [3:0] tap_reg;
	reg [3:0] tap_next;
	reg [3:0] irShift_reg;
	reg [3:0] ir_reg;
	reg [15:0] key_reg;
	reg [14:0] cmd_reg;
	reg holdBit_reg;
	reg bypass_reg;
	reg [7:0] byte_reg;
	reg [2:0] bitCnt_reg;
	reg firstByte_reg;
	reg [31:0] holdCnt_reg;
	reg execArm_reg;
	reg [7:0] fifoOutData;
	wire fifoInReady;
	wire fifoOutValid;
	wire [7:0] fifoData;
	reg fifoInValid;
	reg [7:0] fifoInData;
	wire keyOk;
	wire selKey;
	wire selCmd;
	wire selFill;
	wire selDump;
	wire selHold;
	reg serialOut;
	assign rstB = rstSync_reg[1];
	assign tckRise = tckSync_reg[1] && !tckSync_reg[2];
	assign tckFall = !tckSync_reg[1] && tckSync_reg[2];
	assign tmsS = tmsSync_reg[1];
	assign tdiS = tdiSync_reg[1];
	assign keyOk = (key_reg == `JFP_KEY_VALUE);
	assign selKey = (ir_reg == `JFP_IR_KEY_UNLOCK);
	assign selCmd = (ir_reg == `JFP_IR_CMD_ENTRY);
	assign selFill = (ir_reg == `JFP_IR_PAGE_FILL) && progMode;
	assign selDump = (ir_reg == `JFP_IR_PAGE_DUMP) && progMode;
	assign selHold = (ir_reg == `JFP_IR_CORE_HOLD);
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync_reg <= 2'h0;
		end else begin
			rstSync_reg <= {rstSync_reg[0], 1'b1};
		end
	end
	// third tck stage only feeds the edge detector, never the first stage
	always @(posedge ref_clk or negedge rstB) begin
		if (!rstB) begin
			// tck idles high, so a cleared detector would see a false rise
			tckSync_reg <= 3'h7;
			tmsSync_reg <= 2'h3;
			tdiSync_reg <= 2'h0;
		end else begin
			tckSync_reg <= {tckSync_reg[1:0], tck};
			tmsSync_reg <= {tmsSync_reg[0], tms};
			tdiSync_reg <= {tdiSync_reg[0], tdi};
		end
	end
	always @* begin
		tap_next = tap_reg;
		case (tap_reg)
			TLR: tap_next = tmsS ? TLR : RTI;
			RTI: tap_next = tmsS ? SDS : RTI;
			SDS: tap_next = tmsS ? SIS : CDR;
			CDR: tap_next = tmsS ? E1D : SHDR;
			SHDR: tap_next = tmsS ? E1D : SHDR;
			E1D: tap_next = tmsS ? UDR : PDR;
			PDR: tap_next = tmsS ? E2D : PDR;
			E2D: tap_next = tmsS ? UDR : SHDR;
			UDR: tap_next = tmsS ? SDS : RTI;
			SIS: tap_next = tmsS ? TLR : CIR;
			CIR: tap_next = tmsS ? E1I : SHIR;
			SHIR: tap_next = tmsS ? E1I : SHIR;
			E1I: tap_next = tmsS ? UIR : PIR;
			PIR: tap_next = tmsS ? E2I : PIR;
			E2I: tap_next = tmsS ? UIR : SHIR;
			UIR: tap_next = tmsS ? SDS : RTI;
			default: tap_next = TLR;
		endcase
	end
	always @* begin
		serialOut = bypass_reg;
		if (tap_reg == SHIR) begin
			serialOut = irShift_reg[0];
		end else if (selKey) begin
			serialOut = key_reg[0];
		end else if (selCmd) begin
			serialOut = cmd_reg[0];
		end else if (selFill || selDump) begin
			serialOut = byte_reg[0];
		end else if (selHold) begin
			serialOut = holdBit_reg;
		end
	end
	always @* begin
		fifoInValid = 1'b0;
		fifoInData = {tdiS, byte_reg[7:1]};
		if (tckRise && tap_reg == SHDR && selFill && bitCnt_reg == 3'h7) begin
			fifoInValid = 1'b1;
		end
		fifoOutData = fifoData;
	end
	jfp_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) pageFifo (
		.clk(ref_clk),
		.rstB(rstB),
		.inData(fifoInData),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.outData(fifoData),
		.outValid(fifoOutValid),
		.outReady(!pageWrValid || pageWrReady)
	);
	always @(posedge ref_clk or negedge rstB) begin
		if (!rstB) begin
			tap_reg <= TLR;
			irShift_reg <= 4'h0;
			ir_reg <= `JFP_IR_BYPASS;
			key_reg <= `JFP_KEY_RESET;
			cmd_reg <= `JFP_CMD_RESET;
			holdBit_reg <= 1'b0;
			bypass_reg <= 1'b0;
			byte_reg <= 8'h00;
			bitCnt_reg <= 3'h0;
			firstByte_reg <= 1'b0;
			execArm_reg <= 1'b0;
			tdo <= 1'b0;
			tdoEn <= 1'b0;
			progMode <= 1'b0;
			flashCmd <= 15'h0000;
			flashCmdValid <= 1'b0;
			flashExec <= 1'b0;
			pageWrData <= 8'h00;
			pageWrValid <= 1'b0;
			pageRdReq <= 1'b0;
		end else begin
			flashExec <= 1'b0;
			pageRdReq <= 1'b0;
			if (fifoOutValid && (!pageWrValid || pageWrReady)) begin
				pageWrData <= fifoOutData;
				pageWrValid <= 1'b1;
			end else if (pageWrReady) begin
				pageWrValid <= 1'b0;
			end
			if (tckFall) begin
				tdo <= serialOut;
				tdoEn <= (tap_reg == SHDR) || (tap_reg == SHIR);
			end
			if (tckRise) begin
				tap_reg <= tap_next;
				case (tap_reg)
					TLR: begin
						ir_reg <= `JFP_IR_BYPASS;
					end
					CIR: begin
						irShift_reg <= 4'h1;
					end
					SHIR: begin
						irShift_reg <= {tdiS, irShift_reg[3:1]};
					end
					UIR: begin
						ir_reg <= irShift_reg;
					end
					CDR: begin
						bypass_reg <= 1'b0;
						bitCnt_reg <= 3'h0;
						firstByte_reg <= 1'b1;
						if (selCmd) begin
							cmd_reg <= flashResult;
							cmd_reg[`JFP_DONE_BIT] <= flashDone;
						end
					end
					SHDR: begin
						bypass_reg <= tdiS;
						if (selKey) begin
							key_reg <= {tdiS, key_reg[15:1]};
						end else if (selCmd) begin
							cmd_reg <= {tdiS, cmd_reg[14:1]};
						end else if (selHold) begin
							holdBit_reg <= tdiS;
						end else if (selFill) begin
							// chain length is the host's bit count
							byte_reg <= {tdiS, byte_reg[7:1]};
							bitCnt_reg <= bitCnt_reg + 3'h1;
						end else if (selDump) begin
							// first 8 bits are filler, then page bytes
							bitCnt_reg <= bitCnt_reg + 3'h1;
							if (bitCnt_reg == 3'h7) begin
								byte_reg <= pageRdData;
								pageRdReq <= 1'b1;
								firstByte_reg <= 1'b0;
							end else begin
								byte_reg <= {1'b0, byte_reg[7:1]};
							end
						end
					end
					UDR: begin
						if (selKey) begin
							progMode <= keyOk;
						end
						if (selCmd && progMode) begin
							flashCmd <= cmd_reg;
							flashCmdValid <= 1'b1;
							execArm_reg <= 1'b1;
						end
					end
					RTI: begin
						if (execArm_reg && progMode) begin
							flashExec <= 1'b1;
						end
						execArm_reg <= 1'b0;
					end
					default: begin
						execArm_reg <= execArm_reg;
					end
				endcase
				if (!keyOk) begin
					progMode <= 1'b0;
					flashCmdValid <= 1'b0;
				end
			end
		end
	end
	// hold counter runs from ref_clk so the timeout ends without tck edges
	always @(posedge ref_clk or negedge rstB) begin
		if (!rstB) begin
			holdCnt_reg <= 32'h0;
			coreReset <= 1'b1;
		end else if (holdBit_reg) begin
			holdCnt_reg <= HOLD_CYCLES[31:0];
			coreReset <= 1'b1;
		end else if (holdCnt_reg != 32'h0) begin
			holdCnt_reg <= holdCnt_reg - 32'h1;
			coreReset <= 1'b1;
		end else begin
			coreReset <= 1'b0;
		end
	end
endmodule

// file: tb/jfp_host_model.sv
// jtag host model driving the test access port
`timescale 1ns/100ps
module jfp_host_model (
	input logic ref_clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input logic tdo
);
	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// tdo is taken late in the high phase, before the next fall moves it
	task automatic tick(input logic m, input logic d, output logic q);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge ref_clk);
		tck <= 1'b1;
		repeat (4) @(posedge ref_clk);
		q = tdo;
	endtask
	// starts and ends in idle
	task automatic scan(input logic isIr, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		tick(1'b1, 1'b0, q);
		if (isIr) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		// update tick drives the inverse of the last bit, the idle tick drives the last bit again
		tick(1'b1, ~din[n-1], q);
		tick(1'b0, din[n-1], q);
	endtask
endmodule

// file: tb/jfp_tap_prog_checker.sv
// assertions on the programming tap ports
`timescale 1ns/100ps
module jfp_tap_prog_checker (
	input logic ref_clk,
	input logic rst_b,
	input logic tck,
	input logic tdo,
	input logic progMode,
	input logic coreReset,
	input logic [14:0] flashCmd,
	input logic flashCmdValid,
	input logic flashExec,
	input logic [7:0] pageWrData,
	input logic pageWrValid,
	input logic pageWrReady,
	input logic pageRdReq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	chk_exec_once: assert property (flashExec |=> !flashExec)
		else $error("exec too long");
	chk_exec_mode: assert property (flashExec |-> progMode && flashCmdValid)
		else $error("exec while locked");
	chk_cmd_locked: assert property ($changed(flashCmd) |-> $past(progMode))
		else $error("command while locked");
	chk_tdo_fall: assert property ($changed(tdo) |-> !tck)
		else $error("tdo moved while tck high");
	chk_core_hold: assert property ($fell(coreReset) |-> $past(coreReset, 4))
		else $error("core reset too short");
	chk_wr_hold: assert property (pageWrValid && !pageWrReady |=>
		pageWrValid && $stable(pageWrData)) else $error("fill byte dropped");
	chk_rd_pulse: assert property (pageRdReq |=> !pageRdReq)
		else $error("fetch too long");
	chk_fill_mode: assert property ($rose(pageWrValid) |-> progMode)
		else $error("fill while locked");
endmodule
bind jfp_tap_prog jfp_tap_prog_checker chk (.*);

// file: tb/jfp_tap_prog_tb.sv
// self-checking bench for the jtag programming tap
`timescale 1ns/100ps
module jfp_tap_prog_tb;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic flashDone = 1'b0;
	logic pageWrReady = 1'b1;
	logic [14:0] flashResult = 15'h0000;
	logic [7:0] rdIdx = 8'h00;
	logic tck, tms, tdi, tdo, tdoEn, progMode, coreReset, flashCmdValid, flashExec;
	logic pageWrValid, pageRdReq, qb;
	logic [14:0] flashCmd;
	logic [7:0] pageWrData;
	logic [31:0] got;
	logic [7:0] wr[$];
	int num_errors = 0;
	int n_tests = 0;
	int execs = 0;
	wire logic [7:0] pageRdData = 8'hc3 ^ rdIdx;
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (pageRdReq) rdIdx <= rdIdx + 8'h01;
		if (pageWrValid && pageWrReady) wr.push_back(pageWrData);
		if (flashExec) execs++;
	end
	jfp_host_model host (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	jfp_tap_prog #(.HOLD_CYCLES(4)) dut (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.tdo(tdo),
		.tdoEn(tdoEn),
		.progMode(progMode),
		.coreReset(coreReset),
		.flashCmd(flashCmd),
		.flashCmdValid(flashCmdValid),
		.flashExec(flashExec),
		.flashResult(flashResult),
		.flashDone(flashDone),
		.pageWrData(pageWrData),
		.pageWrValid(pageWrValid),
		.pageWrReady(pageWrReady),
		.pageRdReq(pageRdReq),
		.pageRdData(pageRdData)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic ir(input logic [3:0] c);
		host.scan(1'b1, 4, {28'h0, c}, got);
	endtask
	task automatic dr(input int n, input logic [31:0] d);
		host.scan(1'b0, n, d, got);
	endtask
	task automatic t_reset;
		check(coreReset, 1'b1);
		check(progMode, 1'b0);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		host.tick(1'b0, 1'b0, qb);
		ir(4'hc);
		check(got, 32'h1);
		check(tdoEn, 1'b0);
		$display("reset done");
	endtask
	task automatic t_hold;
		dr(1, 32'h1);
		check(coreReset, 1'b1);
		dr(1, 32'h0);
		check(coreReset, 1'b0);
		$display("hold done");
	endtask
	task automatic t_key;
		ir(4'h5);
		dr(15, 32'h2380);
		host.tick(1'b0, 1'b0, qb);
		repeat (4) @(posedge ref_clk);
		check(flashCmdValid, 1'b0);
		check(execs, 0);
		ir(4'h4);
		dr(16, 32'ha371);
		check(progMode, 1'b0);
		dr(16, 32'ha370);
		check(progMode, 1'b1);
		$display("key done");
	endtask
	task automatic t_cmds;
		// erase, write start, address, data, latch, page write, read start
		logic [14:0] c[14] = '{15'h2380, 15'h3180, 15'h3380, 15'h3380,
			15'h2310, 15'h0712, 15'h13a5, 15'h17c3,
			15'h3700, 15'h7700, 15'h3700,
			15'h3500, 15'h3700,
			15'h2302};
		int e0;
		ir(4'h5);
		foreach (c[i]) begin
			flashResult <= 15'h1234 ^ 15'(i);
			flashDone <= i[0];
			dr(15, {17'h0, c[i]});
			check(got, {17'h0, (15'h1034 ^ 15'(i)) | {5'h0, i[0], 9'h0}});
			e0 = execs;
			host.tick(1'b0, 1'b0, qb);
			repeat (4) @(posedge ref_clk);
			check(flashCmd, c[i]);
			check(execs - e0, 1);
		end
		$display("command done");
	endtask
	task automatic t_fill;
		wr.delete();
		// the dut is the only device on the chain
		ir(4'h6);
		fork
			dr(20, 32'h53ca5);
			begin
				repeat (80) @(posedge ref_clk);
				pageWrReady <= 1'b0;
				repeat (30) @(posedge ref_clk);
				pageWrReady <= 1'b1;
			end
		join
		check(wr.size(), 2);
		check(wr[0], 8'ha5);
		check(wr[1], 8'h3c);
		$display("fill done");
	endtask
	task automatic t_dump;
		logic [7:0] r0;
		r0 = rdIdx;
		ir(4'h7);
		dr(24, 32'hffffff);
		check(got[23:8], {8'hc3 ^ (r0 + 8'h01), 8'hc3 ^ r0});
		$display("dump done");
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		t_reset();
		t_hold();
		t_key();
		t_cmds();
		t_fill();
		t_dump();
		test_done();
	end
	initial begin
		#1000000;
		num_errors++;
		test_done();
	end
endmodule
